// ---- rtl/usb_host_vendor_config_regs.sv ----
// Purpose: vendor configuration registers of the high-speed host function
// Assumes: apb slave, zero wait states, synchronous inputs
// Notes:   preload port models serial-eeprom or smbus default override
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - each adjust unit lengthens the micro-frame by sixteen bit times
// - sof cycle count is 59488 plus the adjust field
// - adjust field resets to 32 for nominal frame length
// - adjust 62 gives 60480 bit times, 63 gives 60496
// - wake mask bit zero reads one, mask implemented
// - wake mask bits one to four map to ports one to four
// - basic mode set lets only one controller be active
// - boundary bit limits upstream read requests to 64 bytes
// - prefetch enable bit turns host memory prefetch on or off
// - user size enable selects the two-bit user read size
// - user size code 00 means 128 bytes, others reserved
// - prefetch size in dwords, reset sixteen
// - control defaults replaceable by smbus or eeprom load
module usb_host_vendor_config_regs #(
	parameter int num_ports = 4
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire usb_cfg_pkg::preload_t  preload,
	input  wire logic [num_ports:1]     port_wake_event,
	output usb_cfg_pkg::usb_ctrl_t      ctrl,
	output logic [num_ports:1]          port_wake_enabled,
	output logic                        sof_pulse
);
	initial begin
		if (num_ports != 4) $error("wake mask serves four ports");
	end

	// ==========================================================
	// bus decode
	logic        acc;
	logic        wr;
	logic        rd_setup;
	logic        hit_frame;
	logic        hit_misc;
	logic        hit_pre;
	logic        hit_stat;
	logic        mapped;
	logic        wr_frame;
	logic        wr_misc;

	// one comparator per register select, so every select decodes the same way
	function automatic logic addr_is(
		input logic [7:0] addr,
		input logic [7:0] offset
	);
		return (addr == offset);
	endfunction : addr_is

	assign acc       = psel & penable;
	assign wr        = acc & pwrite;
	assign rd_setup  = psel & ~penable & ~pwrite;
	assign hit_frame = addr_is(paddr, usb_cfg_pkg::off_frame_word);
	assign hit_misc  = addr_is(paddr, usb_cfg_pkg::off_misc_word);
	// reserved word, decoded so that it answers without an error
	assign hit_pre   = addr_is(paddr, usb_cfg_pkg::off_preload_ctl);
	assign hit_stat  = addr_is(paddr, usb_cfg_pkg::off_status_word);
	assign mapped    = hit_frame | hit_misc | hit_pre | hit_stat;
	// writes land in the access phase; unmapped writes are dropped
	assign wr_frame  = wr & hit_frame;
	assign wr_misc   = wr & hit_misc;

	// ==========================================================
	// byte lane merge
	// lanes without a strobe keep the old value of the word
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction : lane_merge

	// ==========================================================
	// register state
	logic [5:0]  adj_q;
	logic [5:0]  adj_d;
	logic [4:0]  wake_q;
	logic [4:0]  wake_d;
	logic [15:0] misc_q;
	logic [15:0] misc_d;
	logic        preloaded_q;
	logic        preloaded_d;
	logic [31:0] frame_word;
	logic [31:0] misc_word;
	logic [31:0] frame_new;
	logic [31:0] misc_new;
	logic [5:0]  adj_wr;
	logic [4:0]  wake_wr;
	logic [15:0] misc_wr;
	logic [5:0]  pre_adj;
	logic [4:0]  pre_wake;
	logic [15:0] pre_misc;

	// word 0x60 packs the fixed release number, the adjust field and the mask
	assign frame_word  = {11'h000, wake_q, 2'b00, adj_q, usb_cfg_pkg::release_number};
	assign misc_word   = {16'h0000, misc_q};
	assign frame_new   = lane_merge(frame_word, pwdata, pstrb);
	assign misc_new    = lane_merge(misc_word, pwdata, pstrb);
	assign adj_wr      = frame_new[usb_cfg_pkg::frame_adj_lsb +: 6];
	// mask bit 0 is forced so software always sees the mask as present
	assign wake_wr     = frame_new[usb_cfg_pkg::wake_mask_lsb +: 5] | 5'h01;
	// bit 7 and the upper half are read-only zero
	assign misc_wr     = misc_new[15:0] & usb_cfg_pkg::misc_rw_mask;
	// the status flag stays set until the next reset
	assign preloaded_d = preloaded_q | preload.load;
	// preload values pass the same masks as bus writes
	assign pre_adj     = preload.frame_adj;
	assign pre_wake    = preload.wake_mask | 5'h01;
	assign pre_misc    = preload.misc & usb_cfg_pkg::misc_rw_mask;

	// ==========================================================
	// next register values
	// a preload in the same cycle as a bus write wins over the write
	// the adjust field and the mask share one word and one write strobe
	always_comb begin
		adj_d = adj_q;
		if (preload.load) begin
			adj_d = pre_adj;
		end else if (wr_frame) begin
			adj_d = adj_wr;
		end
	end

	always_comb begin
		wake_d = wake_q;
		if (preload.load) begin
			wake_d = pre_wake;
		end else if (wr_frame) begin
			wake_d = wake_wr;
		end
	end

	always_comb begin
		misc_d = misc_q;
		if (preload.load) begin
			misc_d = pre_misc;
		end else if (wr_misc) begin
			misc_d = misc_wr;
		end
	end

	// ==========================================================
	// register flops
	// each register keeps its own reset value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adj_q <= usb_cfg_pkg::frame_adj_reset;
		end else begin
			adj_q <= adj_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_q <= usb_cfg_pkg::wake_mask_reset;
		end else begin
			wake_q <= wake_d;
		end
	end

	// bit 15 resets high and stays writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			misc_q <= usb_cfg_pkg::misc_reset;
		end else begin
			misc_q <= misc_d;
		end
	end

	// sticky: records that the defaults came from a preload
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preloaded_q <= 1'b0;
		end else begin
			preloaded_q <= preloaded_d;
		end
	end

	// ==========================================================
	// read data
	logic [31:0] stat_word;
	logic [31:0] rd_mux;
	logic [31:0] prdata_d;
	logic        pready_d;
	logic        pslverr_d;

	// status word bit 0 reports a completed preload
	assign stat_word = {31'h0, preloaded_q};
	// offset 0x70 and unmapped offsets fall through to zero
	assign rd_mux    = hit_frame ? frame_word :
		hit_misc ? misc_word :
		hit_stat ? stat_word : 32'h0000_0000;
	// read data is captured in the setup phase and stands through the access phase
	assign prdata_d  = rd_setup ? rd_mux : prdata;
	// zero wait states: ready answers every setup phase one cycle later
	assign pready_d  = psel & ~penable;
	// the error flag marks unmapped offsets in the access phase
	assign pslverr_d = psel & ~penable & ~mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else begin
			prdata <= prdata_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= pready_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= pslverr_d;
		end
	end

	// ==========================================================
	// read request size decode
	// only code 00 is defined; reserved codes are held at 128 bytes
	function automatic logic [12:0] user_size_bytes(
		input logic [1:0] code
	);
		logic [12:0] bytes;
		bytes = usb_cfg_pkg::mrrs_128;
		case (code)
			usb_cfg_pkg::user_size_128: begin
				bytes = usb_cfg_pkg::mrrs_128;
			end
			default: begin
				bytes = usb_cfg_pkg::mrrs_128;
			end
		endcase
		return bytes;
	endfunction : user_size_bytes

	// ==========================================================
	// control field views
	// reserved bits 3 and 15 are stored but drive nothing
	logic        basic_bit;
	logic        b64_en;
	logic        pref_bit;
	logic        user_en;
	logic [1:0]  user_code;
	logic [6:0]  pfsize;
	logic [12:0] user_limit;
	logic [12:0] limit_sel;
	logic [15:0] sof_count;

	assign basic_bit  = misc_q[usb_cfg_pkg::misc_basic_bit];
	assign b64_en     = misc_q[usb_cfg_pkg::misc_b64_bit];
	assign pref_bit   = misc_q[usb_cfg_pkg::misc_pref_bit];
	assign user_en    = misc_q[usb_cfg_pkg::misc_user_en_bit];
	assign user_code  = misc_q[usb_cfg_pkg::misc_user_lsb +: 2];
	assign pfsize     = misc_q[usb_cfg_pkg::misc_pfsize_lsb +: 7];
	assign user_limit = user_size_bytes(user_code);
	// 64 is below every user size, so the boundary bit takes priority
	// the user size only counts while its enable bit is set
	assign limit_sel  = b64_en ? usb_cfg_pkg::mrrs_64 :
		user_en ? user_limit : usb_cfg_pkg::mrrs_default;
	// one count unit per 16 bit times on the micro-frame
	assign sof_count  = usb_cfg_pkg::sof_base_count + {10'h000, adj_q};

	// ==========================================================
	// control outputs
	// reset clears the outputs; the first edge after reset loads the defaults
	usb_cfg_pkg::usb_ctrl_t ctrl_d;

	assign ctrl_d.basic_mode      = basic_bit;
	assign ctrl_d.prefetch_en     = pref_bit;
	assign ctrl_d.prefetch_dwords = pfsize;
	assign ctrl_d.max_read_bytes  = limit_sel;
	assign ctrl_d.sof_cycle_count = sof_count;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '0;
		end else begin
			ctrl <= ctrl_d;
		end
	end

	// ==========================================================
	// per-port wake gating
	// mask bit n gates port n; bit 0 only marks the mask as present
	// the event is a level; the output follows it one cycle late
	logic [num_ports:1] wake_gate_d;

	genvar p;
	generate
		for (p = 1; p <= num_ports; p++) begin : g_wake
			assign wake_gate_d[p] = port_wake_event[p] & wake_q[p];
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_wake_enabled <= '0;
		end else begin
			port_wake_enabled <= wake_gate_d;
		end
	end

	// ==========================================================
	// sof interval
	// the timer compares against the registered count, one cycle behind the field
	// the pulse lasts one cycle per interval
	sof_interval_timer #(
		.count_width(16)
	) u_sof (
		.pclk       (pclk),
		.presetn    (presetn),
		.cycle_count(ctrl.sof_cycle_count),
		.sof_pulse  (sof_pulse)
	);
endmodule : usb_host_vendor_config_regs

// ---- rtl/usb_cfg_pkg.sv ----
// Purpose: constants and carriers for the host vendor configuration registers
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   word 0x60 holds release number, length adjust and wake mask
package usb_cfg_pkg;
	localparam logic [7:0]  off_frame_word    = 8'h60;
	localparam logic [7:0]  off_misc_word     = 8'h68;
	localparam logic [7:0]  off_preload_ctl   = 8'h70;
	localparam logic [7:0]  off_status_word   = 8'h74;
	localparam logic [7:0]  release_number    = 8'h20;
	localparam int          frame_adj_lsb     = 8;
	localparam int          wake_mask_lsb     = 16;
	localparam logic [5:0]  frame_adj_reset   = 6'h20;
	localparam logic [4:0]  wake_mask_reset   = 5'h0f;
	localparam logic [15:0] sof_base_count    = 16'd59488;
	localparam int          bit_times_per_unit = 16;
	localparam int          misc_basic_bit    = 0;
	localparam int          misc_b64_bit      = 1;
	localparam int          misc_pref_bit     = 2;
	localparam int          misc_rsv3_bit     = 3;
	localparam int          misc_user_en_bit  = 4;
	localparam int          misc_user_lsb     = 5;
	localparam int          misc_pfsize_lsb   = 8;
	localparam int          misc_rsv15_bit    = 15;
	localparam logic [15:0] misc_reset        = 16'h9000;
	localparam logic [15:0] misc_rw_mask      = 16'hff7f;
	localparam logic [1:0]  user_size_128     = 2'b00;
	localparam logic [12:0] mrrs_64           = 13'd64;
	localparam logic [12:0] mrrs_128          = 13'd128;
	localparam logic [12:0] mrrs_default      = 13'd512;

	typedef struct packed {
		logic        basic_mode;
		logic        prefetch_en;
		logic [6:0]  prefetch_dwords;
		logic [12:0] max_read_bytes;
		logic [15:0] sof_cycle_count;
	} usb_ctrl_t;

	typedef struct packed {
		logic        load;
		logic [5:0]  frame_adj;
		logic [4:0]  wake_mask;
		logic [15:0] misc;
	} preload_t;
endpackage : usb_cfg_pkg

// ---- rtl/sof_interval_timer.sv ----
// Purpose: micro-frame sof interval counter
// Assumes: counter clock is pclk
// Notes:   count restarts at each frame boundary; the period is compared every cycle
`timescale 1ns/1ps
module sof_interval_timer #(
	parameter int count_width = 16
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic [count_width-1:0] cycle_count,
	output logic                        sof_pulse
);
	initial begin
		if (count_width < 16) $error("count_width too small");
	end

	logic [count_width-1:0] cnt_q;
	logic [count_width-1:0] cnt_d;
	logic                   wrap;

	assign wrap  = (cnt_q >= cycle_count - count_width'(1));
	assign cnt_d = wrap ? '0 : cnt_q + count_width'(1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q     <= '0;
			sof_pulse <= 1'b0;
		end else begin
			cnt_q     <= cnt_d;
			sof_pulse <= wrap;
		end
	end
endmodule : sof_interval_timer

// ---- tb/usb_cfg_regs_sva.sv ----
// Purpose: port checks for the host vendor configuration registers
// Assumes: one clock, async active-low reset
// Notes:   bound to the register block
`timescale 1ns/1ps
module usb_cfg_regs_sva #(
	parameter int num_ports = 4
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [7:0]            paddr,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [num_ports:1]    port_wake_event,
	input wire usb_cfg_pkg::usb_ctrl_t ctrl,
	input wire logic [num_ports:1]    port_wake_enabled,
	input wire logic                  sof_pulse
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire setup = psel && !penable;
	wire hole  = !(paddr inside {8'h60, 8'h68, 8'h70, 8'h74});
	chk_ready_setup: assert property (setup |=> pready)
		else $error("no ready after setup");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	chk_err_hole: assert property (setup && hole |=> pslverr)
		else $error("no error on unmapped");
	chk_ok_mapped: assert property (setup && !hole |=> !pslverr)
		else $error("error on mapped");
	chk_hole_zero: assert property (setup && !pwrite && hole |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_read_limit: assert property ($past(presetn) |->
		ctrl.max_read_bytes inside {13'd64, 13'd128, 13'd512})
		else $error("bad read limit");
	chk_sof_range: assert property ($past(presetn) |->
		ctrl.sof_cycle_count inside {[16'd59488:16'd59551]})
		else $error("sof count out of range");
	chk_sof_single: assert property (sof_pulse |=> !sof_pulse [*8])
		else $error("sof pulse too long");
	chk_wake_gated: assert property ($past(presetn) |->
		(port_wake_enabled & ~$past(port_wake_event)) == '0)
		else $error("wake without event");
endmodule : usb_cfg_regs_sva
bind usb_host_vendor_config_regs usb_cfg_regs_sva #(.num_ports(num_ports)) sva_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl(ctrl),
	.port_wake_event(port_wake_event), .port_wake_enabled(port_wake_enabled),
	.sof_pulse(sof_pulse));

// ---- tb/usb_host_vendor_config_regs_tb_top.sv ----
// Purpose: self-checking bench for the vendor configuration registers
// Assumes: apb master at pclk rising edge
// Notes:   reads queue expectations, monitor compares
`timescale 1ns/1ps
module usb_host_vendor_config_regs_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic [3:0]  pstrb = 4'hf, wev = 0, wen;
	logic        pready, pslverr, sof_pulse;
	logic [5:0]  a;
	logic [32:0] q[$];
	logic [31:0] mw[3] = '{32'hffffffff, 32'h15, 32'h0};
	logic [12:0] mr[3] = '{13'd64, 13'd128, 13'd512};
	int num_errors = 0, n_checks = 0, sof_n = 0;
	usb_cfg_pkg::preload_t  preload = '0;
	usb_cfg_pkg::usb_ctrl_t ctrl;
	usb_host_vendor_config_regs usb_host_vendor_config_regs_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .preload(preload),
		.port_wake_event(wev), .ctrl(ctrl), .port_wake_enabled(wen), .sof_pulse(sof_pulse));
	always #5 pclk = ~pclk;
	task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] s);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask : cmp
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d,
		input logic [32:0] e);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		if (!w) q.push_back(e);
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : xfer
	task automatic stop_test;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	always @(posedge pclk) if (psel && penable && pready && !pwrite)
		cmp("prdata", q.pop_front(), {pslverr, prdata});
	// =====================================
	// tests
	initial begin
		void'($urandom(27));
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		xfer(0, 8'h60, 0, 33'h0000f2020);
		xfer(0, 8'h68, 0, 33'h000009000);
		xfer(0, 8'h7c, 0, 33'h100000000);
		cmp("prefetch_dwords", 33'd16, 33'(ctrl.prefetch_dwords));
		for (int i = 0; i < 4; i++) begin
			a = (i < 2) ? 6'd62 + 6'(i) : 6'($urandom);
			xfer(1, 8'h60, {11'h0, 5'h0a, 2'b11, a, 8'hff}, 0);
			xfer(0, 8'h60, 0, {12'h0, 5'h0b, 2'b0, a, 8'h20});
			cmp("sof_count", 33'd59488 + 33'(a), 33'(ctrl.sof_cycle_count));
		end
		wev <= 4'hf;
		repeat (2) @(posedge pclk);
		cmp("wake", 33'h5, 33'(wen));
		pstrb <= 4'h4;
		xfer(1, 8'h60, 0, 0);
		pstrb <= 4'hf;
		xfer(0, 8'h60, 0, {12'h0, 5'h01, 2'b0, a, 8'h20});
		for (int i = 0; i < 3; i++) begin
			xfer(1, 8'h68, mw[i], 0);
			xfer(0, 8'h68, 0, {17'h0, mw[i][15:8], 1'b0, mw[i][6:0]});
			cmp("read_limit", 33'(mr[i]), 33'(ctrl.max_read_bytes));
			cmp("misc_ctrl", {mw[i][0], mw[i][2], mw[i][14:8]},
				{ctrl.basic_mode, ctrl.prefetch_en, ctrl.prefetch_dwords});
		end
		preload <= '{load: 1'b1, frame_adj: 6'h3e, wake_mask: 5'h10, misc: 16'h0006};
		@(posedge pclk);
		preload.load <= 0;
		@(posedge pclk);
		xfer(0, 8'h60, 0, 33'h000113e20);
		xfer(0, 8'h68, 0, 33'h000000006);
		xfer(0, 8'h74, 0, 33'h000000001);
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		do begin
			@(posedge pclk);
			sof_n++;
		end while (sof_pulse !== 1'b1);
		// nominal period plus one cycle for the registered pulse
		cmp("sof_period", 33'd59488 + 33'd32 + 33'd1, 33'(sof_n));
		xfer(0, 8'h60, 0, 33'h0000f2020);
		xfer(0, 8'h74, 0, 33'h000000000);
		stop_test();
	end
	initial begin
		#900us;
		num_errors++;
		stop_test();
	end
endmodule : usb_host_vendor_config_regs_tb_top
